// ---- hw/ebls_pkg.sv ----
package ebls_pkg;
    // access sizes from the load/store unit
    typedef enum logic [1:0] {EBLS_SIZE_BYTE, EBLS_SIZE_HALF, EBLS_SIZE_WORD} ebls_size_type;
    localparam int          LANES      = 4;
    localparam int          LANE_W     = 8;
    localparam int          DATA_W     = 32;
    localparam logic        ORDER_LE   = 1'h1;   // byte_order_select value for little-endian
    localparam logic [1:0]  OFS_0      = 2'h0;
    localparam logic [1:0]  OFS_2      = 2'h2;
    localparam logic [3:0]  BE_NONE    = 4'h0;
    localparam logic [3:0]  BE_BYTE    = 4'h1;
    localparam logic [3:0]  BE_HALF    = 4'h3;
    localparam logic [3:0]  BE_WORD    = 4'hf;
    localparam logic [31:0] DATA_RESET = 32'h0000_0000;
endpackage : ebls_pkg

// ---- hw/ebls_steer.sv ----
// Behaviour
// - bus side always little-endian lane order
// - big-endian: base address selects most significant byte
// - big-endian: higher address, lower significance
// - little-endian: base address selects least significant byte
// - little-endian: higher address, higher significance
// - conversion only reverses bytes: four in a word, two in a half
// - select bit one means little-endian
// - little-endian aligned word passes unchanged
// - little half at offset zero: lanes one, zero
// - little half at offset two: lanes three, two
// - little byte offset zero on lane zero
// - little byte offset one on lane one
// - little bytes offsets two, three on lanes two, three
// - host word reads back unchanged
// - host word base byte: 04 big, 07 little
// - byte at offset n rides lane n
// - byte three on 31:24 down to byte 0 on 7:0
`timescale 1ns/1ps
module ebls_steer (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  byte_order_select,
    input  wire logic                  req_valid,
    input  wire logic                  req_write,
    input  wire ebls_pkg::ebls_size_type req_size,
    input  wire logic [1:0]            req_offset,
    input  wire logic [31:0]           req_store_data,
    output logic                       bus_valid,
    output logic                       bus_write,
    output logic [3:0]                 bus_byte_en,
    output logic [31:0]                bus_wdata,
    input  wire logic                  bus_rvalid,
    input  wire logic [31:0]           bus_rdata,
    output logic                       load_valid,
    output logic [31:0]                load_data
);
    logic [31:0] swap_st;
    logic [31:0] swap_ld;
    logic [31:0] lane_wdata;
    logic [3:0]  lane_en;
    logic [31:0] lane_word;
    logic [31:0] load_next;
    logic [1:0]  rd_ofs_reg;
    ebls_pkg::ebls_size_type rd_size_reg;

    // reversal of bytes is the only conversion
    function automatic logic [31:0] byte_rev(input logic [31:0] w);
        byte_rev = {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction : byte_rev

    // lanes stay little-endian; big mode swaps whole word
    assign swap_st = (byte_order_select == ebls_pkg::ORDER_LE) ? req_store_data : byte_rev(req_store_data);

    // store steering: low bits of register moved to addressed lanes
    always_comb
    begin
        lane_wdata = req_store_data;
        lane_en    = ebls_pkg::BE_NONE;
        case (req_size)
            ebls_pkg::EBLS_SIZE_WORD:
            begin
                lane_wdata = swap_st;
                lane_en    = ebls_pkg::BE_WORD;
            end
            ebls_pkg::EBLS_SIZE_HALF:
            begin
                // half-word lands on lanes 1:0 or 3:2
                if (byte_order_select == ebls_pkg::ORDER_LE)
                    lane_wdata = {2{req_store_data[15:0]}};
                else
                    lane_wdata = {2{req_store_data[7:0], req_store_data[15:8]}};
                lane_en = (req_offset[1] ? ebls_pkg::BE_HALF << ebls_pkg::OFS_2 : ebls_pkg::BE_HALF);
            end
            ebls_pkg::EBLS_SIZE_BYTE:
            begin
                lane_wdata = {4{req_store_data[7:0]}};
                lane_en    = ebls_pkg::BE_BYTE << req_offset;
            end
            default:
            begin
                lane_en = ebls_pkg::BE_NONE;
            end
        endcase
    end

    // lane k of the bus is bits 8k+7:8k
    assign bus_valid   = req_valid;
    assign bus_write   = req_write;
    assign bus_byte_en = lane_en;
    assign bus_wdata   = lane_wdata;

    // remember shape of the pending load; one outstanding load assumed
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rd_ofs_reg  <= ebls_pkg::OFS_0;
            rd_size_reg <= ebls_pkg::EBLS_SIZE_WORD;
        end
        else if (req_valid && !req_write)
        begin
            rd_ofs_reg  <= req_offset;
            rd_size_reg <= req_size;
        end
    end

    // load side undoes the same swap
    assign swap_ld   = (byte_order_select == ebls_pkg::ORDER_LE) ? bus_rdata : byte_rev(bus_rdata);
    assign lane_word = bus_rdata >> {rd_ofs_reg, 3'h0};

    // right-align sub-word loads; upper bits left as lane junk
    always_comb
    begin
        load_next = lane_word;
        case (rd_size_reg)
            ebls_pkg::EBLS_SIZE_WORD:
                load_next = swap_ld;
            ebls_pkg::EBLS_SIZE_HALF:
            begin
                // big mode: lower address byte is the more significant
                if (byte_order_select == ebls_pkg::ORDER_LE)
                    load_next = lane_word;
                else
                    load_next = {lane_word[31:16], lane_word[7:0], lane_word[15:8]};
            end
            ebls_pkg::EBLS_SIZE_BYTE:
                // base byte of host word is lane 0 in both modes
                load_next = lane_word;
            default:
                load_next = lane_word;
        endcase
    end

    // load data registered; valid follows the bus answer by one cycle
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            load_valid <= 1'b0;
            load_data  <= ebls_pkg::DATA_RESET;
        end
        else
        begin
            load_valid <= bus_rvalid;
            if (bus_rvalid)
                load_data <= load_next;
        end
    end

    a_le_word_pass: assert property (@(posedge clk) disable iff (!rst_n)
        (req_valid && req_write && byte_order_select && req_size == ebls_pkg::EBLS_SIZE_WORD)
        |-> bus_wdata == req_store_data) else $error("little word store reordered");
    a_be_word_swap: assert property (@(posedge clk) disable iff (!rst_n)
        (req_valid && req_write && !byte_order_select && req_size == ebls_pkg::EBLS_SIZE_WORD)
        |-> bus_wdata == {req_store_data[7:0], req_store_data[15:8], req_store_data[23:16], req_store_data[31:24]})
        else $error("big word store not swapped");
    // a_byte_lane_n: byte on lane given by offset
    a_byte_lane_n: assert property (@(posedge clk) disable iff (!rst_n)
        (req_valid && req_write && req_size == ebls_pkg::EBLS_SIZE_BYTE)
        |-> bus_byte_en == (4'h1 << req_offset)
            && bus_wdata[req_offset*8 +: 8] == req_store_data[7:0]) else $error("byte on wrong lane");
    // a_le_half_hi: half at offset two on upper lanes
    a_le_half_hi: assert property (@(posedge clk) disable iff (!rst_n)
        (req_valid && req_write && byte_order_select && req_size == ebls_pkg::EBLS_SIZE_HALF && req_offset == 2'h2)
        |-> bus_byte_en == 4'hc && bus_wdata[31:16] == req_store_data[15:0]) else $error("half not on lanes 3:2");
    // a_le_half_lo: half at offset zero on lower lanes
    a_le_half_lo: assert property (@(posedge clk) disable iff (!rst_n)
        (req_valid && req_write && byte_order_select && req_size == ebls_pkg::EBLS_SIZE_HALF && req_offset == 2'h0)
        |-> bus_byte_en == 4'h3 && bus_wdata[15:0] == req_store_data[15:0]) else $error("half not on lanes 1:0");
    // a_be_half_store: big half store swaps its two bytes
    a_be_half_store: assert property (@(posedge clk) disable iff (!rst_n)
        (req_valid && req_write && !byte_order_select && req_size == ebls_pkg::EBLS_SIZE_HALF && req_offset == 2'h0)
        |-> bus_byte_en == 4'h3 && bus_wdata[15:0] == {req_store_data[7:0], req_store_data[15:8]})
        else $error("big half store not swapped");

    // load answers named by mode and shape; the shape was caught at the request edge
    sequence s_le_word_answer;
        bus_rvalid && byte_order_select && rd_size_reg == ebls_pkg::EBLS_SIZE_WORD;
    endsequence
    sequence s_big_word_answer;
        bus_rvalid && !byte_order_select && rd_size_reg == ebls_pkg::EBLS_SIZE_WORD;
    endsequence
    sequence s_le_half_answer;
        bus_rvalid && byte_order_select && rd_size_reg == ebls_pkg::EBLS_SIZE_HALF && rd_ofs_reg == ebls_pkg::OFS_0;
    endsequence

    // a_word_load_back: little word load returns lanes as they are
    a_word_load_back: assert property (@(posedge clk) disable iff (!rst_n)
        s_le_word_answer |=> load_valid && load_data == $past(bus_rdata)) else $error("little word load changed");
    // a_be_word_load: big word load reverses the lanes
    a_be_word_load: assert property (@(posedge clk) disable iff (!rst_n)
        s_big_word_answer |=> load_valid
            && load_data[31:24] == $past(bus_rdata[7:0]) && load_data[23:16] == $past(bus_rdata[15:8])
            && load_data[15:8] == $past(bus_rdata[23:16]) && load_data[7:0] == $past(bus_rdata[31:24]))
        else $error("big word load not reversed");
    // a_le_half_load: little half load keeps lane order
    a_le_half_load: assert property (@(posedge clk) disable iff (!rst_n)
        s_le_half_answer |=> load_data[15:0] == $past(bus_rdata[15:0])) else $error("little half load reordered");
    // a_byte_load_lane: byte at offset zero comes from lane zero
    a_byte_load_lane: assert property (@(posedge clk) disable iff (!rst_n)
        (bus_rvalid && rd_size_reg == ebls_pkg::EBLS_SIZE_BYTE && rd_ofs_reg == 2'h0)
        |=> load_data[7:0] == $past(bus_rdata[7:0])) else $error("base byte load wrong");
    // a_byte_load_one: byte at offset one comes from lane one
    a_byte_load_one: assert property (@(posedge clk) disable iff (!rst_n)
        (bus_rvalid && rd_size_reg == ebls_pkg::EBLS_SIZE_BYTE && rd_ofs_reg == 2'h1)
        |=> load_data[7:0] == $past(bus_rdata[15:8])) else $error("lane one byte load wrong");
    // a_byte_load_two: byte at offset two comes from lane two
    a_byte_load_two: assert property (@(posedge clk) disable iff (!rst_n)
        (bus_rvalid && rd_size_reg == ebls_pkg::EBLS_SIZE_BYTE && rd_ofs_reg == 2'h2)
        |=> load_data[7:0] == $past(bus_rdata[23:16])) else $error("lane two byte load wrong");
    // a_byte_load_top: byte at offset three comes from lane three
    a_byte_load_top: assert property (@(posedge clk) disable iff (!rst_n)
        (bus_rvalid && rd_size_reg == ebls_pkg::EBLS_SIZE_BYTE && rd_ofs_reg == 2'h3)
        |=> load_data[7:0] == $past(bus_rdata[31:24])) else $error("top byte load wrong");
    // a_be_half_load: big half load puts lower address byte high
    a_be_half_load: assert property (@(posedge clk) disable iff (!rst_n)
        (bus_rvalid && rd_size_reg == ebls_pkg::EBLS_SIZE_HALF && rd_ofs_reg == 2'h0 && !byte_order_select)
        |=> load_data[15:8] == $past(bus_rdata[7:0])) else $error("big half load order wrong");
    // a_load_pulse: load strobe trails the bus answer by one edge
    a_load_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        load_valid == $past(bus_rvalid)) else $error("load strobe out of step");
    // a_load_hold: load word kept until the next answer
    a_load_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !bus_rvalid |=> $stable(load_data)) else $error("load word changed without answer");
endmodule : ebls_steer

// ---- dv/ebls_far_mem.sv ----
`timescale 1ns/1ps
// far side: one address-invariant memory word, loads answered after a chosen delay
module ebls_far_mem (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [1:0]  delay,
    input  wire logic        bus_valid,
    input  wire logic        bus_write,
    input  wire logic [3:0]  bus_byte_en,
    input  wire logic [31:0] bus_wdata,
    output logic             bus_rvalid,
    output logic [31:0]      bus_rdata
);
    logic [31:0] word_reg;
    logic [1:0]  wait_reg;
    logic        pend_reg;
    // lane k keeps byte offset k, never reordered here
    always @(posedge clk)
    begin
        for (int k = 0; k < 4; k++)
            if (bus_valid && bus_write && bus_byte_en[k])
                word_reg[8*k +: 8] <= bus_wdata[8*k +: 8];
    end
    // idle data toggles so a stale word never passes for an answer
    always @(posedge clk)
    begin
        bus_rvalid <= 1'b0;
        bus_rdata  <= rst_n ? ~bus_rdata : 32'h5a5a_a5a5;
        if (!rst_n)
            pend_reg <= 1'b0;
        else if (bus_valid && !bus_write)
        begin
            pend_reg <= 1'b1;
            wait_reg <= delay;
        end
        else if (pend_reg && wait_reg != 2'h0)
            wait_reg <= wait_reg - 2'h1;
        else if (pend_reg)
        begin
            pend_reg   <= 1'b0;
            bus_rvalid <= 1'b1;
            bus_rdata  <= word_reg;
        end
    end
endmodule : ebls_far_mem

// ---- dv/endian_byte_lane_steering_test.sv ----
`timescale 1ns/1ps
module endian_byte_lane_steering_test;
    logic        clk, rst_n, byte_order_select, req_valid, req_write, bus_valid, bus_write, bus_rvalid, load_valid;
    logic [1:0]  req_offset, delay, ofs;
    logic [3:0]  bus_byte_en;
    logic [31:0] req_store_data, bus_wdata, bus_rdata, load_data, mem_word;
    ebls_pkg::ebls_size_type req_size, s;
    int          error_cnt = 0, cmp_count = 0, cycles = 0, seed = 32'hd20d;
    ebls_steer uut (.clk, .rst_n, .byte_order_select, .req_valid, .req_write, .req_size, .req_offset,
        .req_store_data, .bus_valid, .bus_write, .bus_byte_en, .bus_wdata, .bus_rvalid, .bus_rdata,
        .load_valid, .load_data);
    ebls_far_mem far (.clk, .rst_n, .delay, .bus_valid, .bus_write, .bus_byte_en, .bus_wdata, .bus_rvalid,
        .bus_rdata);
    function automatic logic [31:0] swap4(logic [31:0] w);
        return {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction : swap4
    // register value to lanes; big mode reverses bytes, sub-words replicated
    function automatic logic [31:0] lanes_of(ebls_pkg::ebls_size_type z, logic [31:0] d);
        if (z == ebls_pkg::EBLS_SIZE_WORD)
            return byte_order_select ? d : swap4(d);
        if (z == ebls_pkg::EBLS_SIZE_HALF)
            return byte_order_select ? {2{d[15:0]}} : {2{d[7:0], d[15:8]}};
        return {4{d[7:0]}};
    endfunction : lanes_of
    // lanes to register, right-aligned; mask keeps only defined bits
    function automatic logic [31:0] load_of(ebls_pkg::ebls_size_type z, logic [1:0] o, logic [31:0] w);
        if (z == ebls_pkg::EBLS_SIZE_WORD)
            return byte_order_select ? w : swap4(w);
        if (z == ebls_pkg::EBLS_SIZE_HALF)
            return byte_order_select ? w >> 16*o[1] : swap4(w >> 16*o[1]) >> 16;
        return w >> 8*o;
    endfunction : load_of
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic drive(logic wr, logic [1:0] o, logic [31:0] d);
        @(negedge clk);
        {req_valid, req_write, req_offset, req_store_data} = {1'b1, wr, o, d};
        req_size = s;
        delay    = 2'($random(seed));
    endtask : drive
    task automatic store(logic [1:0] o, logic [31:0] d);
        logic [31:0] m;
        logic [3:0]  b;
        drive(1'b1, o, d);
        b = s == ebls_pkg::EBLS_SIZE_WORD ? 4'hf : s == ebls_pkg::EBLS_SIZE_HALF ? (o[1] ? 4'hc : 4'h3) : 4'h1 << o;
        for (int k = 0; k < 4; k++)
            m[8*k +: 8] = {8{b[k]}};
        #1;
        check("ben", {27'h0, bus_valid & bus_write, bus_byte_en}, {28'h1, b});
        check("wdata", bus_wdata & m, lanes_of(s, d) & m);
        mem_word = (mem_word & ~m) | (lanes_of(s, d) & m);
    endtask : store
    task automatic load(logic [1:0] o);
        logic [31:0] m;
        m = ~(32'hffff_ffff << (8 << s)); // word shifts by 32, leaving all ones
        drive(1'b0, o, $random(seed));
        #1;
        check("load req", {30'h0, bus_valid, bus_write}, 32'h2);
        @(negedge clk);
        req_valid = 1'b0;
        for (int n = 0; n < 8 && load_valid !== 1'b1; n++)
            @(negedge clk);
        check("load_valid", {31'h0, load_valid}, 32'h1);
        check("load_data", load_data & m, load_of(s, o, mem_word) & m);
    endtask : load
    // the mode bit is changed only between requests
    task automatic set_mode(logic le);
        @(negedge clk);
        req_valid         = 1'b0;
        byte_order_select = le;
    endtask : set_mode
    task automatic complete_run;
        $display("counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // a hang counts as a mismatch
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            error_cnt++;
            complete_run();
        end
    end
    initial
    begin
        {rst_n, req_valid, req_write, byte_order_select, req_offset, delay, req_store_data} = 40'h0;
        s        = ebls_pkg::EBLS_SIZE_WORD;
        req_size = s;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        check("reset load_valid", {31'h0, load_valid}, 32'h0);
        check("reset load_data", load_data, 32'h0);
        // host-written word; big host puts its first byte 04 on lane 0
        for (int le = 1; le >= 0; le--)
        begin
            set_mode(le[0]);
            mem_word = le ? 32'h0405_0607 : 32'h0706_0504;
            far.word_reg = mem_word;
            s = ebls_pkg::EBLS_SIZE_WORD;
            load(2'h0);
            s = ebls_pkg::EBLS_SIZE_BYTE;
            load(2'h0);
        end
        $display("test host_word done");
        // mid-run reset must clear the held load word
        @(negedge clk);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        check("mid reset load_valid", {31'h0, load_valid}, 32'h0);
        check("mid reset load_data", load_data, 32'h0);
        $display("test mid_reset done");
        // every size and aligned offset in both orders, back to back
        for (int i = 0; i < 24; i++)
        begin
            set_mode(i[0]);
            s = ebls_pkg::ebls_size_type'(i / 8 % 3);
            if (i[2:1] == 2'h0 || (s == ebls_pkg::EBLS_SIZE_BYTE) || (s == ebls_pkg::EBLS_SIZE_HALF && !i[1]))
            begin
                store({i[2:1]}, 32'h0102_0304);
                load({i[2:1]});
            end
        end
        $display("test lane_table done");
        repeat (300)
        begin
            if ($random(seed) % 8 == 0)
                set_mode(1'($random(seed)));
            s = ebls_pkg::ebls_size_type'($unsigned($random(seed)) % 3);
            // offset kept in the bench; a store still held must not see its lanes move
            ofs = 2'($random(seed)) & (s == ebls_pkg::EBLS_SIZE_HALF ? 2'h2 : 2'h3);
            if (s == ebls_pkg::EBLS_SIZE_WORD)
                ofs = 2'h0;
            if ($random(seed) & 1)
                store(ofs, $random(seed));
            else
                load(ofs);
        end
        $display("test random done");
        complete_run();
    end
endmodule : endian_byte_lane_steering_test
